//--- verilog/hth_pkg.sv
// package for the host transfer handshake block
// assumes one 100 MHz clock and a strapped host-port style input
package hth_pkg;
    localparam int unsigned DATA_W         = 16;
    localparam int unsigned ADDR_W         = 16;
    localparam int unsigned CLK_PERIOD_NS  = 10;
    // internal register/ram access time, in ns
    localparam int unsigned XFER_TIME_NS   = 40;
    localparam int unsigned XFER_CYCLES    =
        (XFER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W          = 8;
    localparam logic        MODE_BUFFERED  = 1'b0;
    localparam logic        MODE_TRANSP    = 1'b1;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_XFER,
        ST_DONE,
        ST_WAIT_REL
    } hth_state_t;
endpackage : hth_pkg

//--- verilog/hth_access_timer.sv
// access timer: counts the internal transfer duration
// assumes start is a one-cycle pulse in the CLK_IN domain
`timescale 1ns/1ps
module hth_access_timer #(
    parameter int unsigned CYCLES = hth_pkg::XFER_CYCLES,
    parameter int unsigned CNT_W  = hth_pkg::CNT_W
) (
    input  wire logic CLK_IN,
    input  wire logic NRST_IN,
    input  wire logic start_in,
    output logic      busy_out,
    output logic      done_out
);
    import hth_pkg::*;

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             done_r;
    logic             done_nxt;

    // load on start, count down to zero; done marks the last busy cycle
    // so the caller can take read data while the request still stands
    always_comb begin
        cnt_nxt = cnt_r;
        if (start_in) begin
            cnt_nxt = CNT_W'(CYCLES);
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
        end
        done_nxt = (cnt_nxt == CNT_W'(1));
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            cnt_r  <= '0;
            done_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy_out = (cnt_r != '0);
    assign done_out = done_r;
endmodule : hth_access_timer

//--- verilog/hth_host_port.sv
// host port handshake: ready and buffer enable for host accesses
// assumes host strobe, address and data are synchronous to CLK_IN
// and that internal storage answers through mem_* ports in fixed time
`timescale 1ns/1ps

// Summary of operation
// - wait-state read: ready goes low once read data is on bus
// - wait-state write: ready goes low once word reached storage
// - zero-wait mode: ready rests high while new cycle accepted
// - zero-wait mode: ready falls when internal transfer begins
// - zero-wait mode: ready rises again when internal transfer ends
// - buffer enable low exactly while a host access is carried out
module hth_host_port #(
    parameter int unsigned DW = hth_pkg::DATA_W,
    parameter int unsigned AW = hth_pkg::ADDR_W
) (
    input  wire logic          CLK_IN,
    input  wire logic          NRST_IN,
    input  wire logic          HOST_STYLE_IN,
    input  wire logic          HOST_STROBE_N_IN,
    input  wire logic          HOST_RD_WR_N_IN,
    input  wire logic [AW-1:0] HOST_ADDR_IN,
    input  wire logic [DW-1:0] HOST_DATA_IN,
    output logic      [DW-1:0] HOST_DATA_OUT,
    output logic               HOST_DATA_OE_OUT,
    output logic               TRANSFER_READY_N_OUT,
    output logic               IO_BUFFER_ENABLE_N_OUT,
    output logic               MEM_REQ_OUT,
    output logic               MEM_WE_OUT,
    output logic      [AW-1:0] MEM_ADDR_OUT,
    output logic      [DW-1:0] MEM_WDATA_OUT,
    input  wire logic [DW-1:0] MEM_RDATA_IN
);
    import hth_pkg::*;

    hth_state_t      state_r;
    hth_state_t      state_nxt;
    logic            strobe_d_r;
    logic            mode_r;
    logic            mode_nxt;
    logic            rd_r;
    logic            rd_nxt;
    logic [AW-1:0]   addr_r;
    logic [AW-1:0]   addr_nxt;
    logic [DW-1:0]   wdata_r;
    logic [DW-1:0]   wdata_nxt;
    logic [DW-1:0]   rdata_r;
    logic [DW-1:0]   rdata_nxt;
    logic            start;
    logic            t_busy;
    logic            t_done;
    logic            strobe_fall;

    // new cycle seen on falling strobe edge
    assign strobe_fall = strobe_d_r && !HOST_STROBE_N_IN;

    // strap sampled each idle cycle; it is static in practice
    always_comb begin
        state_nxt = state_r;
        mode_nxt  = mode_r;
        rd_nxt    = rd_r;
        addr_nxt  = addr_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        start     = 1'b0;
        case (state_r)
            ST_IDLE: begin
                mode_nxt = HOST_STYLE_IN;
                if (strobe_fall) begin
                    start     = 1'b1;
                    rd_nxt    = HOST_RD_WR_N_IN;
                    addr_nxt  = HOST_ADDR_IN;
                    wdata_nxt = HOST_DATA_IN;
                    state_nxt = ST_XFER;
                end
            end
            ST_XFER: begin
                // leave on the last access cycle: storage still answers,
                // so read data is taken before the request drops
                if (t_done) begin
                    if (rd_r) begin
                        rdata_nxt = MEM_RDATA_IN;
                    end
                    state_nxt = (mode_r == MODE_BUFFERED) ? ST_WAIT_REL
                                                          : ST_DONE;
                end
            end
            ST_DONE: begin
                // ready held low until host releases strobe
                if (HOST_STROBE_N_IN) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_WAIT_REL: begin
                // buffered: transfer over; wait strobe high if still low
                if (HOST_STROBE_N_IN) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            state_r    <= ST_IDLE;
            strobe_d_r <= 1'b1;
            mode_r     <= MODE_BUFFERED;
            rd_r       <= 1'b0;
            addr_r     <= '0;
            wdata_r    <= '0;
            rdata_r    <= '0;
        end else begin
            state_r    <= state_nxt;
            strobe_d_r <= HOST_STROBE_N_IN;
            mode_r     <= mode_nxt;
            rd_r       <= rd_nxt;
            addr_r     <= addr_nxt;
            wdata_r    <= wdata_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    hth_access_timer #(
        .CYCLES (XFER_CYCLES),
        .CNT_W  (CNT_W)
    ) u_timer (
        .CLK_IN   (CLK_IN),
        .NRST_IN  (NRST_IN),
        .start_in (start),
        .busy_out (t_busy),
        .done_out (t_done)
    );

    // internal storage request runs while the timer is busy
    assign MEM_REQ_OUT   = t_busy;
    assign MEM_WE_OUT    = t_busy && !rd_r;
    assign MEM_ADDR_OUT  = addr_r;
    assign MEM_WDATA_OUT = wdata_r;

    // wait-state: low in ST_DONE; zero-wait: low while transferring
    always_comb begin
        if (mode_r == MODE_TRANSP) begin
            TRANSFER_READY_N_OUT = (state_r != ST_DONE);
        end else begin
            TRANSFER_READY_N_OUT = (state_r != ST_XFER);
        end
    end

    // enable low only during the access itself; same span as the
    // storage request, so external buffers open only while in flight
    assign IO_BUFFER_ENABLE_N_OUT = (state_r != ST_XFER);
    assign HOST_DATA_OUT    = rdata_r;
    assign HOST_DATA_OE_OUT = rd_r && (state_r == ST_DONE) &&
                              !HOST_STROBE_N_IN;

    // checks: each guards one promise made to the host
    AST_RD_DATA_AT_READY: assert property (@(posedge CLK_IN)
        disable iff (!NRST_IN)
        (mode_r == MODE_TRANSP && rd_r && $fell(TRANSFER_READY_N_OUT))
        |-> HOST_DATA_OE_OUT && HOST_DATA_OUT == $past(MEM_RDATA_IN))
        else $error("read ready without data");
    AST_WR_BEFORE_READY: assert property (@(posedge CLK_IN)
        disable iff (!NRST_IN)
        (mode_r == MODE_TRANSP && !rd_r && $fell(TRANSFER_READY_N_OUT))
        |-> $past(MEM_WE_OUT))
        else $error("write ready before store");
    AST_ZW_READY_IDLE: assert property (@(posedge CLK_IN)
        disable iff (!NRST_IN)
        (mode_r == MODE_BUFFERED && state_r == ST_IDLE)
        |-> TRANSFER_READY_N_OUT)
        else $error("zero-wait ready low when idle");
    AST_ZW_READY_FALL: assert property (@(posedge CLK_IN)
        disable iff (!NRST_IN)
        (mode_r == MODE_BUFFERED && strobe_fall && state_r == ST_IDLE)
        |=> !TRANSFER_READY_N_OUT && MEM_REQ_OUT)
        else $error("zero-wait ready did not fall");
    AST_ZW_READY_RISE: assert property (@(posedge CLK_IN)
        disable iff (!NRST_IN)
        (mode_r == MODE_BUFFERED && $fell(TRANSFER_READY_N_OUT))
        |-> ##4 TRANSFER_READY_N_OUT)
        else $error("zero-wait ready did not rise");
    AST_IO_BUFFER_ENABLE_N_MATCH: assert property (@(posedge CLK_IN)
        disable iff (!NRST_IN)
        !IO_BUFFER_ENABLE_N_OUT |-> MEM_REQ_OUT)
        else $error("buffer enable outside access");
    AST_IO_BUFFER_ENABLE_N_LEN: assert property (@(posedge CLK_IN)
        disable iff (!NRST_IN)
        $fell(IO_BUFFER_ENABLE_N_OUT)
        |-> !IO_BUFFER_ENABLE_N_OUT [*4] ##1 IO_BUFFER_ENABLE_N_OUT)
        else $error("buffer enable wrong length");
    AST_WS_HOLD: assert property (@(posedge CLK_IN)
        disable iff (!NRST_IN)
        (state_r == ST_DONE && !HOST_STROBE_N_IN)
        |=> !TRANSFER_READY_N_OUT)
        else $error("ready released while strobe low");
    // data bus driven only in the ready phase of a wait-state read
    AST_OE_READ_ONLY: assert property (@(posedge CLK_IN)
        disable iff (!NRST_IN)
        HOST_DATA_OE_OUT |-> rd_r && !TRANSFER_READY_N_OUT)
        else $error("data bus driven outside read");

    // main scenarios
    COV_WS_READ: cover property (@(posedge CLK_IN)
        mode_r == MODE_TRANSP && rd_r && $fell(TRANSFER_READY_N_OUT));
    COV_WS_WRITE: cover property (@(posedge CLK_IN)
        mode_r == MODE_TRANSP && !rd_r && $fell(TRANSFER_READY_N_OUT));
    COV_ZW_CYCLE: cover property (@(posedge CLK_IN)
        mode_r == MODE_BUFFERED && $rose(TRANSFER_READY_N_OUT));
    COV_ZW_READ: cover property (@(posedge CLK_IN)
        mode_r == MODE_BUFFERED && rd_r && $rose(TRANSFER_READY_N_OUT));
    COV_WS_LONG_HOLD: cover property (@(posedge CLK_IN)
        state_r == ST_DONE && !HOST_STROBE_N_IN ##1
        state_r == ST_DONE && !HOST_STROBE_N_IN);
endmodule : hth_host_port

//--- test/hth_host_model.sv
// host processor model: one strobe cycle per call of xfer
// assumes ready and read data settle within 1 ns after an edge
`timescale 1ns/1ps
module hth_host_model (
    input  wire logic        clk_in,
    input  wire logic        ready_n_in,
    input  wire logic        io_en_n_in,
    input  wire logic        oe_in,
    input  wire logic [15:0] rdata_in,
    output logic             strobe_n_out,
    output logic             rd_wr_n_out,
    output logic      [15:0] addr_out,
    output logic      [15:0] wdata_out
);
    // idle bus at time zero, strobe high
    initial begin
        strobe_n_out = 1'b1;
        rd_wr_n_out  = 1'b1;
        addr_out     = 16'h0000;
        wdata_out    = 16'h0000;
    end
    // buffered: short strobe, then wait for ready high before returning
    task automatic xfer(input logic rd, input logic bufd,
            input logic [15:0] a, input logic [15:0] d, input int hold,
            output logic [15:0] q, output int lat, output int rl,
            output int el, output int ol);
        int i;
        lat = 0;
        rl  = 0;
        el  = 0;
        ol  = 0;
        q   = 16'h0000;
        @(posedge clk_in);
        strobe_n_out <= 1'b0;
        rd_wr_n_out  <= rd;
        addr_out     <= a;
        wdata_out    <= d;
        for (i = 1; i < 40; i++) begin
            @(posedge clk_in);
            if (bufd ? i == 1 : (lat != 0 && i == lat + hold)) begin
                strobe_n_out <= 1'b1;
                wdata_out    <= ~d; // released bus must not look stale
            end
            #1;
            if (ready_n_in === 1'b0 && lat == 0) begin
                lat = i;
                q   = rdata_in;
            end
            rl += (ready_n_in === 1'b0);
            el += (io_en_n_in === 1'b0);
            ol += (oe_in === 1'b1);
            if (lat != 0 && ready_n_in === 1'b1 && strobe_n_out) break;
        end
    endtask : xfer
endmodule : hth_host_model

//--- test/host_transfer_handshake_tb.sv
// self-checking bench for the host port handshake
// assumes a 16-word storage model behind the mem ports
`timescale 1ns/1ps
module host_transfer_handshake_tb;
    import hth_pkg::*;
    logic        clk = 1'b0, nrst = 1'b0, style = MODE_TRANSP;
    logic        stb_n, rw, oe, rdy_n, en_n, mreq, mwe;
    logic [15:0] addr, wd, dout, maddr, mwd;
    logic [15:0] mem [16];
    logic [15:0] exp_mem [16];
    int          error_cnt = 0, check_count = 0;

    always #5 clk = ~clk;
    // storage answers at once; writes land on the access edge
    always @(posedge clk) if (mreq && mwe) mem[maddr[3:0]] <= mwd;

    hth_host_port dut (.CLK_IN(clk), .NRST_IN(nrst),
        .HOST_STYLE_IN(style), .HOST_STROBE_N_IN(stb_n),
        .HOST_RD_WR_N_IN(rw), .HOST_ADDR_IN(addr), .HOST_DATA_IN(wd),
        .HOST_DATA_OUT(dout), .HOST_DATA_OE_OUT(oe),
        .TRANSFER_READY_N_OUT(rdy_n), .IO_BUFFER_ENABLE_N_OUT(en_n),
        .MEM_REQ_OUT(mreq), .MEM_WE_OUT(mwe), .MEM_ADDR_OUT(maddr),
        .MEM_WDATA_OUT(mwd), .MEM_RDATA_IN(mem[maddr[3:0]]));
    hth_host_model host (.clk_in(clk), .ready_n_in(rdy_n),
        .io_en_n_in(en_n), .oe_in(oe), .rdata_in(dout),
        .strobe_n_out(stb_n),
        .rd_wr_n_out(rw), .addr_out(addr), .wdata_out(wd));

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        check_count++;
        if (seen !== ex) begin
            error_cnt++;
            $display("[FAIL] %s expected %0h seen %0h", nm, ex, seen);
        end
    endtask : chk

    task results;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    // idle outputs, checked while each reset is still held
    task chk_idle;
        chk("ready idle", rdy_n, 1);
        chk("buf enable idle", en_n, 1);
        chk("mem req idle", mreq, 0);
    endtask : chk_idle

    initial begin
        logic [15:0] q, a, d;
        logic        rd, md;
        int          lat, rl, el, ol, hold, k;
        k = $urandom(62863);
        for (k = 0; k < 16; k++) begin
            mem[k]     = 16'h0000;
            exp_mem[k] = 16'h0000;
        end
        repeat (5) @(posedge clk);
        #1 chk_idle();
        @(posedge clk) nrst <= 1'b1;
        for (k = 0; k < 48; k++) begin
            // mode changes only while idle; corners mixed into random
            md = ((k % 16) < 8) ? MODE_TRANSP : MODE_BUFFERED;
            @(posedge clk) style <= md;
            rd = (k < 2) ? k[0] : 1'($urandom_range(1, 0));
            a  = (k % 7 == 3) ? 16'hFFFF : 16'($urandom);
            d  = (k % 5 == 1) ? 16'h0000 : 16'($urandom);
            hold = $urandom_range(4, 1);
            host.xfer(rd, md == MODE_BUFFERED, a, d, hold, q, lat, rl,
                      el, ol);
            if (lat == 0) begin
                chk("ready seen", 0, 1);
                results();
            end
            if (!rd) exp_mem[a[3:0]] = d;
            chk("access cycles", el, XFER_CYCLES);
            if (md == MODE_TRANSP) begin
                chk("ready latency", lat, XFER_CYCLES + 1);
                chk("ready held", rl, hold + 1);
                if (rd) chk("read data", q, exp_mem[a[3:0]]);
                chk("read drive", ol, rd ? hold : 0);
            end else begin
                chk("read drive", ol, 0);
                chk("ready fall", lat, 1);
                chk("ready low span", rl, XFER_CYCLES);
            end
            chk("stored word", mem[a[3:0]], exp_mem[a[3:0]]);
            repeat (2) @(posedge clk);
            #1 chk("ready rest", rdy_n, 1);
            if (k == 30) begin
                @(posedge clk) nrst <= 1'b0;
                repeat (2) @(posedge clk);
                #1 chk_idle();
                @(posedge clk) nrst <= 1'b1;
            end
        end
        results();
    end
endmodule : host_transfer_handshake_tb
